// ### rtl/pcc_consts.svh
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// Command codes of the result registers
`define PCC_CMD_CAP2      8'h49
`define PCC_CMD_CAP3      8'h4a
`define PCC_CMD_CAP4      8'h4b
`define PCC_CMD_CLS1      8'h4c
`define PCC_CMD_CLS2      8'h4d
`define PCC_CMD_CLS3      8'h4e
`define PCC_CMD_CLS4      8'h4f

// Channel indices (channel 1 is index 0)
`define PCC_CH1           0
`define PCC_CH2           1
`define PCC_CH3           2
`define PCC_CH4           3

// Reset value of every result register
`define PCC_REG_RST       8'h00
`define PCC_NIB_RST       4'h0

// Capacitance count weight in nanofarad, usable span in nanofarad
`define PCC_CAP_LSB_NF    50
`define PCC_CAP_MIN_NF    1000
`define PCC_CAP_MAX_NF    12000

// Class byte layout
`define PCC_GRANT_MSB     7
`define PCC_GRANT_LSB     4
`define PCC_EARLIER_MSB   3
`define PCC_EARLIER_LSB   0

// Class codes
`define PCC_CLS_UNKNOWN   4'h0
`define PCC_CLS_ONE       4'h1
`define PCC_CLS_THREE     4'h3
`define PCC_CLS_FOUR      4'h4
`define PCC_CLS_ZERO      4'h6
`define PCC_CLS_4P_LO     4'h8
`define PCC_CLS_4P_HI     4'hb

`endif

// ### rtl/pcc_pkg.sv
package pcc_pkg;

	typedef enum logic [1:0] {
		PCC_MODE_OFF,
		PCC_MODE_MANUAL,
		PCC_MODE_SEMI,
		PCC_MODE_AUTO
	} pcc_mode_e;

	typedef logic [7:0] pcc_byte_t;
	typedef logic [3:0] pcc_nib_t;

endpackage : pcc_pkg

// ### rtl/pcc_chan_if.sv
`timescale 1ns/10ps
interface pcc_chan_if;
	import pcc_pkg::*;

	pcc_mode_e mode;
	logic      sense_probe_enable;
	logic      class_enable;
	logic      sram_loaded;
	logic      turn_off;
	logic      det_done;
	logic      res_valid;
	logic      cap_done;
	pcc_byte_t capacitance_count;
	logic      grant_stb;
	pcc_nib_t  granted_power_level;
	logic      earlier_stb;
	pcc_nib_t  earlier_power_level;
	pcc_byte_t cap_q;
	pcc_byte_t class_q;
	logic      cap_start;

	modport ctl (
		output mode, sense_probe_enable, class_enable, sram_loaded,
		output turn_off, det_done, res_valid, cap_done,
		output capacitance_count, grant_stb, granted_power_level,
		output earlier_stb, earlier_power_level,
		input  cap_q, class_q, cap_start
	);

	modport chn (
		input  mode, sense_probe_enable, class_enable, sram_loaded,
		input  turn_off, det_done, res_valid, cap_done,
		input  capacitance_count, grant_stb, granted_power_level,
		input  earlier_stb, earlier_power_level,
		output cap_q, class_q, cap_start
	);

endinterface : pcc_chan_if

// ### rtl/pcc_chan.sv
`timescale 1ns/10ps
`include "pcc_consts.svh"

module pcc_chan #(
	parameter bit HAS_CAP = 1'b1
) (
	input  wire logic       sys_clk_i,
	input  wire logic       arst_n_i,
	pcc_chan_if.chn         ch
);
	import pcc_pkg::*;

	logic      busy_q;
	logic      busy_d;
	logic      start_d;
	logic      take_cap;
	logic      take_grant;
	logic      take_earlier;
	logic      is_manual;
	logic      earlier_ok;
	pcc_nib_t  grant_map;
	pcc_nib_t  code;
	pcc_nib_t  grant_d;
	pcc_nib_t  earlier_d;
	pcc_byte_t cap_d;

	assign is_manual = (ch.mode == PCC_MODE_MANUAL);

	// Start only after an invalid resistance result, in manual mode
	assign start_d = HAS_CAP && ch.det_done && !ch.res_valid
	                 && is_manual
	                 && ch.sram_loaded && !busy_q && !ch.turn_off;

	// Whole count taken in one edge at the end of the measurement
	assign take_cap = HAS_CAP && busy_q && ch.cap_done && is_manual;
	assign cap_d    = take_cap ? ch.capacitance_count : ch.cap_q;

	assign busy_d = start_d ||
	                (busy_q && !ch.cap_done && !ch.turn_off && is_manual);

	// A class 0 device is granted class 3; other unknown codes stay unknown
	assign code = ch.granted_power_level;
	assign grant_map = (code == `PCC_CLS_ZERO) ? `PCC_CLS_THREE :
	                   (code >= `PCC_CLS_ONE && code <= `PCC_CLS_FOUR)
	                   ? code : `PCC_CLS_UNKNOWN;

	assign earlier_ok = (ch.earlier_power_level <= `PCC_CLS_FOUR) ||
	                    (ch.earlier_power_level == `PCC_CLS_ZERO) ||
	                    (ch.earlier_power_level >= `PCC_CLS_4P_LO &&
	                     ch.earlier_power_level <= `PCC_CLS_4P_HI);

	// Manual mode powers a channel with no granted class
	assign take_grant   = ch.grant_stb && !is_manual;
	assign take_earlier = ch.earlier_stb && earlier_ok &&
	                      ch.mode == PCC_MODE_SEMI &&
	                      ch.sense_probe_enable && ch.class_enable;

	// Turn-off clears the class byte and takes priority over an update
	assign grant_d = ch.turn_off ? `PCC_NIB_RST :
	                 take_grant ? grant_map
	                 : ch.class_q[`PCC_GRANT_MSB:`PCC_GRANT_LSB];
	assign earlier_d = ch.turn_off ? `PCC_NIB_RST :
	                   take_earlier ? ch.earlier_power_level
	                   : ch.class_q[`PCC_EARLIER_MSB:`PCC_EARLIER_LSB];

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ch.cap_q     <= `PCC_REG_RST;
			ch.class_q   <= `PCC_REG_RST;
			ch.cap_start <= 1'b0;
			busy_q       <= 1'b0;
		end
		else
		begin
			ch.cap_q     <= cap_d;
			ch.class_q   <= {grant_d, earlier_d};
			ch.cap_start <= start_d;
			busy_q       <= busy_d;
		end
	end

endmodule : pcc_chan

// ### rtl/pcc_result_regs.sv
`timescale 1ns/10ps
`include "pcc_consts.svh"

// Operation
// - Capacitance is an unsigned 8-bit count, each step 0.05 uF, 1 to 12 uF.
// - Capacitance result survives channel turn-off unchanged.
// - Capacitance measured only while the channel is in manual mode.
// - No capacitance measurement after a valid resistance detection.
// - Turn-off clears both nibbles of the channel's class byte.
// - Granted class in bits 7-4: 0 unknown, 1-4 classes, rest reserved.
// - Earlier class result sits in bits 3-0 of the class byte.
// - Each result has its own read-only code, one byte per transfer.
// - All result registers read zero after reset until updated.
// - Earlier class codes: 0 unknown, 1-4, 6 class 0, 8-b four-pair.
// - Earlier class valid only in semi-auto with detect and class on.
// - A class 0 device is granted class 3 when powered.
// - Channel 2 capacitance has the first result code; channel 1 has no capacitance code.
module pcc_result_regs (
	input  wire logic                  sys_clk_i,
	input  wire logic                  arst_n_i,
	// Host command port, one byte per transfer
	input  wire logic [7:0]            cmd_code_i,
	input  wire logic                  rd_stb_i,
	input  wire logic                  wr_stb_i,
	input  wire logic [7:0]            wr_data_i,
	output logic      [7:0]            rd_data_o,
	output logic                       rd_valid_o,
	output logic                       rd_miss_o,
	output logic                       wr_refused_o,
	// Channel state from the channel controller; sram_loaded_i is one bit shared by all four channels
	input  pcc_pkg::pcc_mode_e         chan_mode_i [4],
	input  wire logic [3:0]            sense_probe_enable_i,
	input  wire logic [3:0]            class_enable_i,
	input  wire logic                  sram_loaded_i,
	input  wire logic [3:0]            turn_off_i,
	// Measurement engine handshake
	input  wire logic [3:0]            det_done_i,
	input  wire logic [3:0]            res_valid_i,
	input  wire logic [3:0]            cap_done_i,
	input  wire logic [3:0][7:0]       capacitance_count_i,
	output logic      [3:0]            cap_start_o,
	// Classification results
	input  wire logic [3:0]            grant_stb_i,
	input  wire logic [3:0][3:0]       granted_power_level_i,
	input  wire logic [3:0]            earlier_stb_i,
	input  wire logic [3:0][3:0]       earlier_power_level_i
);
	import pcc_pkg::*;

	pcc_chan_if ch_if [4] ();

	logic [3:0] cap_start_w;

	// One result slice per channel; channel 1 keeps no capacitance here
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_chan
			assign ch_if[g].mode                = chan_mode_i[g];
			assign ch_if[g].sense_probe_enable  = sense_probe_enable_i[g];
			assign ch_if[g].class_enable        = class_enable_i[g];
			assign ch_if[g].sram_loaded         = sram_loaded_i;
			assign ch_if[g].turn_off            = turn_off_i[g];
			assign ch_if[g].det_done            = det_done_i[g];
			assign ch_if[g].res_valid           = res_valid_i[g];
			assign ch_if[g].cap_done            = cap_done_i[g];
			assign ch_if[g].capacitance_count   = capacitance_count_i[g];
			assign ch_if[g].grant_stb           = grant_stb_i[g];
			assign ch_if[g].granted_power_level = granted_power_level_i[g];
			assign ch_if[g].earlier_stb         = earlier_stb_i[g];
			assign ch_if[g].earlier_power_level = earlier_power_level_i[g];
			assign cap_start_w[g]               = ch_if[g].cap_start;

			pcc_chan #(
				.HAS_CAP (g != `PCC_CH1)
			) u_chan (
				.sys_clk_i (sys_clk_i),
				.arst_n_i  (arst_n_i),
				.ch        (ch_if[g])
			);
		end
	endgenerate

	// Stored results brought out by name for the read decode
	pcc_byte_t cap2_w;
	pcc_byte_t cap3_w;
	pcc_byte_t cap4_w;
	pcc_byte_t cls1_w;
	pcc_byte_t cls2_w;
	pcc_byte_t cls3_w;
	pcc_byte_t cls4_w;

	assign cap2_w = ch_if[`PCC_CH2].cap_q;
	assign cap3_w = ch_if[`PCC_CH3].cap_q;
	assign cap4_w = ch_if[`PCC_CH4].cap_q;
	assign cls1_w = ch_if[`PCC_CH1].class_q;
	assign cls2_w = ch_if[`PCC_CH2].class_q;
	assign cls3_w = ch_if[`PCC_CH3].class_q;
	assign cls4_w = ch_if[`PCC_CH4].class_q;

	// Command decode
	logic hit_cap2;
	logic hit_cap3;
	logic hit_cap4;
	logic hit_cls1;
	logic hit_cls2;
	logic hit_cls3;
	logic hit_cls4;
	logic hit_any;

	assign hit_cap2 = (cmd_code_i == `PCC_CMD_CAP2);
	assign hit_cap3 = (cmd_code_i == `PCC_CMD_CAP3);
	assign hit_cap4 = (cmd_code_i == `PCC_CMD_CAP4);
	assign hit_cls1 = (cmd_code_i == `PCC_CMD_CLS1);
	assign hit_cls2 = (cmd_code_i == `PCC_CMD_CLS2);
	assign hit_cls3 = (cmd_code_i == `PCC_CMD_CLS3);
	assign hit_cls4 = (cmd_code_i == `PCC_CMD_CLS4);
	assign hit_any  = hit_cap2 | hit_cap3 | hit_cap4 |
	                  hit_cls1 | hit_cls2 | hit_cls3 | hit_cls4;

	// Read selection; unmapped codes return zero
	pcc_byte_t rd_sel;

	assign rd_sel = hit_cap2 ? cap2_w :
	                hit_cap3 ? cap3_w :
	                hit_cap4 ? cap4_w :
	                hit_cls1 ? cls1_w :
	                hit_cls2 ? cls2_w :
	                hit_cls3 ? cls3_w :
	                hit_cls4 ? cls4_w : `PCC_REG_RST;

	// Writes never reach storage; a write to one of our codes is flagged
	logic wr_refused_d;
	logic wr_data_seen;

	assign wr_data_seen = |wr_data_i;
	assign wr_refused_d = wr_stb_i & hit_any & (wr_data_seen | ~wr_data_seen);

	// Read answer one edge after the strobe, a whole byte at a time
	pcc_byte_t rd_data_d;
	logic      rd_valid_d;
	logic      rd_miss_d;

	assign rd_data_d  = rd_stb_i ? rd_sel : rd_data_o;
	assign rd_valid_d = rd_stb_i;
	assign rd_miss_d  = rd_stb_i & ~hit_any;

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rd_data_o    <= `PCC_REG_RST;
			rd_valid_o   <= 1'b0;
			rd_miss_o    <= 1'b0;
			wr_refused_o <= 1'b0;
			cap_start_o  <= '0;
		end
		else
		begin
			rd_data_o    <= rd_data_d;
			rd_valid_o   <= rd_valid_d;
			rd_miss_o    <= rd_miss_d;
			wr_refused_o <= wr_refused_d;
			cap_start_o  <= cap_start_w;
		end
	end

endmodule : pcc_result_regs

// ### dv/pcc_result_checker.sv
`timescale 1ns/10ps
`include "pcc_consts.svh"
module pcc_result_checker
	import pcc_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [7:0] cmd_code_i,
	input  wire logic       rd_stb_i,
	input  wire logic       wr_stb_i,
	input  wire logic [7:0] rd_data_o,
	input  wire logic       rd_valid_o,
	input  wire logic       rd_miss_o,
	input  wire logic       wr_refused_o,
	input  pcc_pkg::pcc_mode_e chan_mode_i [4],
	input  wire logic [3:0] det_done_i,
	input  wire logic [3:0] res_valid_i,
	input  wire logic       sram_loaded_i,
	input  wire logic [3:0] cap_start_o
);
	wire logic mapped_w = cmd_code_i >= `PCC_CMD_CAP2 &&
		cmd_code_i <= `PCC_CMD_CLS4;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	rd_answer_a: assert property (rd_stb_i |=> rd_valid_o)
		else $error("read not answered");
	rd_quiet_a: assert property (!rd_stb_i |=> !rd_valid_o && !rd_miss_o)
		else $error("answer without read");
	rd_hit_a: assert property (rd_stb_i && mapped_w |=> !rd_miss_o)
		else $error("mapped read flagged as miss");
	rd_miss_a: assert property (rd_stb_i && !mapped_w |=> rd_miss_o)
		else $error("unmapped read not flagged");
	rd_hold_a: assert property (!rd_stb_i |=> $stable(rd_data_o))
		else $error("read data moved without read");
	wr_flag_a: assert property (wr_stb_i && mapped_w |=> wr_refused_o)
		else $error("write to result not refused");
	wr_quiet_a: assert property (!wr_stb_i |=> !wr_refused_o)
		else $error("refusal without write");
	start_cause_a: assert property (cap_start_o[1] |->
		$past(det_done_i[1], 2) && !$past(res_valid_i[1], 2) &&
		$past(sram_loaded_i, 2)) else $error("start without cause");
	start_mode_a: assert property (cap_start_o[2] |->
		$past(chan_mode_i[2], 2) == PCC_MODE_MANUAL)
		else $error("start outside manual mode");
endmodule : pcc_result_checker

bind pcc_result_regs pcc_result_checker chk_u (
	.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cmd_code_i(cmd_code_i),
	.rd_stb_i(rd_stb_i), .wr_stb_i(wr_stb_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .rd_miss_o(rd_miss_o),
	.wr_refused_o(wr_refused_o), .chan_mode_i(chan_mode_i),
	.det_done_i(det_done_i), .res_valid_i(res_valid_i),
	.sram_loaded_i(sram_loaded_i), .cap_start_o(cap_start_o)
);

// ### dv/pcc_host_model.sv
`timescale 1ns/10ps
module pcc_host_model (
	input  wire logic       sys_clk_i,
	output logic      [7:0] cmd_code_o,
	output logic            rd_stb_o,
	output logic            wr_stb_o,
	output logic      [7:0] wr_data_o,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i
);
	initial
	begin
		cmd_code_o = 8'h00;
		rd_stb_o = 1'b0;
		wr_stb_o = 1'b0;
		wr_data_o = 8'h00;
	end
	// One byte per command code, no address increment
	task xfer(input bit wr, input logic [7:0] code,
		output logic [7:0] data, output logic vld);
		@(posedge sys_clk_i);
		#1;
		cmd_code_o = code;
		rd_stb_o = !wr;
		wr_stb_o = wr;
		wr_data_o = 8'($urandom);
		@(posedge sys_clk_i);
		#1;
		rd_stb_o = 1'b0;
		wr_stb_o = 1'b0;
		cmd_code_o = ~code;
		data = rd_data_i;
		vld = rd_valid_i;
	endtask : xfer
endmodule : pcc_host_model

// ### dv/test_pse_capacitance_class_regs.sv
`timescale 1ns/10ps
module test_pse_capacitance_class_regs
	import pcc_pkg::*;
;
	logic clk, rst_n, sram, rs, ws, v, go, ex, ab;
	pcc_mode_e mode [4];
	logic [3:0] spe, cle, toff, detd, resv, capd, gstb, estb, cst;
	logic [3:0][7:0] cnt;
	logic [3:0][3:0] glev, elev;
	logic [7:0] cmd, wd, rdat, d;
	int failures, n_compared, k, c, g, e, capm[4], clsm[4];

	pcc_host_model host_u (.sys_clk_i(clk), .cmd_code_o(cmd),
		.rd_stb_o(rs), .wr_stb_o(ws), .wr_data_o(wd),
		.rd_data_i(rdat), .rd_valid_i(v));
	pcc_result_regs dut_u (.sys_clk_i(clk), .arst_n_i(rst_n),
		.cmd_code_i(cmd), .rd_stb_i(rs), .wr_stb_i(ws), .wr_data_i(wd),
		.rd_data_o(rdat), .rd_valid_o(v), .rd_miss_o(), .wr_refused_o(),
		.chan_mode_i(mode), .sense_probe_enable_i(spe),
		.class_enable_i(cle), .sram_loaded_i(sram), .turn_off_i(toff),
		.det_done_i(detd), .res_valid_i(resv), .cap_done_i(capd),
		.capacitance_count_i(cnt), .cap_start_o(cst),
		.grant_stb_i(gstb), .granted_power_level_i(glev),
		.earlier_stb_i(estb), .earlier_power_level_i(elev));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [7:0] expv(input int a);
		if (a >= 8'h49 && a <= 8'h4b)
			return 8'(capm[a - 8'h48]);
		if (a >= 8'h4c && a <= 8'h4f)
			return 8'(clsm[a - 8'h4c]);
		return 8'h00;
	endfunction : expv

	task chk(input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : chk

	task rdchk(input int a);
		host_u.xfer(1'b0, 8'(a), d, go);
		chk(expv(a), d);
		chk(8'h01, {7'h00, go});
	endtask : rdchk

	task tick;
		@(posedge clk);
		#1;
	endtask : tick

	task conclude;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	initial
	begin
		#100000;
		failures++;
		conclude;
	end

	initial
	begin
		{rst_n, sram, spe, cle, toff, detd, resv, capd, gstb, estb} = '0;
		{cnt, glev, elev} = '0;
		mode = '{default: PCC_MODE_OFF};
		k = $urandom(45675);
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (c = 8'h48; c <= 8'h50; c++)
			rdchk(c);
		$display("reset values done");
		repeat (80)
		begin
			k = $urandom % 4;
			// Bias towards manual mode so channels 2 to 4 start measurements
			mode[k] = ($urandom % 2) ? PCC_MODE_MANUAL :
				pcc_mode_e'($urandom % 4);
			sram = $urandom % 4 != 0;
			resv[k] = $urandom % 4 == 0;
			detd[k] = 1'b1;
			tick;
			detd[k] = 1'b0;
			ex = k != 0 && !resv[k] && mode[k] == PCC_MODE_MANUAL && sram;
			go = 1'b0;
			repeat (3)
			begin
				tick;
				go = go | cst[k];
			end
			chk({7'h00, ex}, {7'h00, go});
			// Some measurements are cut short by a turn-off
			ab = ex && $urandom % 4 == 0;
			toff[k] = ab;
			tick;
			toff[k] = 1'b0;
			if (ab)
				clsm[k] = 0;
			cnt[k] = 8'($urandom);
			capd[k] = 1'b1;
			tick;
			capd[k] = 1'b0;
			if (ex && !ab)
				capm[k] = cnt[k];
			rdchk(8'h48 + k);
			rdchk(8'h4c + k);
		end
		$display("capacitance done");
		repeat (60)
		begin
			k = $urandom % 4;
			mode[k] = pcc_mode_e'($urandom % 4);
			{spe, cle} = 8'($urandom);
			{glev[k], elev[k]} = 8'($urandom);
			toff[k] = $urandom % 4 == 0;
			{gstb[k], estb[k]} = 2'b11;
			tick;
			g = glev[k];
			e = elev[k];
			if (toff[k])
				clsm[k] = 0;
			else
			begin
				if (mode[k] != PCC_MODE_MANUAL)
					clsm[k] = clsm[k] % 16 + 16 * (g == 6 ? 3 :
						(g >= 1 && g <= 4) ? g : 0);
				if (mode[k] == PCC_MODE_SEMI && spe[k] && cle[k] &&
					(e <= 4 || e == 6 || (e >= 8 && e <= 11)))
					clsm[k] = clsm[k] / 16 * 16 + e;
			end
			{toff[k], gstb[k], estb[k]} = 3'b000;
			rdchk(8'h4c + k);
			rdchk(8'h48 + k);
		end
		$display("class done");
		for (c = 8'h48; c <= 8'h50; c++)
		begin
			host_u.xfer(1'b1, 8'(c), d, go);
			chk(8'h00, {7'h00, go});
			rdchk(c);
		end
		$display("write refusal done");
		// Reset in mid-run must clear results that hold data by now
		rst_n = 1'b0;
		repeat (2) tick;
		rst_n = 1'b1;
		for (c = 0; c < 4; c++)
		begin
			capm[c] = 0;
			clsm[c] = 0;
		end
		for (c = 8'h48; c <= 8'h50; c++)
			rdchk(c);
		$display("mid-run reset done");
		conclude;
	end
endmodule : test_pse_capacitance_class_regs
